// [inc/eac_pkg.sv]
// Summary of operation
// - emitter register: trim revision high, code low
// - emitter drive equals code times ten milliamps
// - emitter code resets to two, twenty milliamps
// - codes above twenty clamp to 200 mA
// - trim revision read only, shows fused identifier
// - self-timed run keeps old code until recycled
// - top ambient bit enables continuous conversion, resets zero
// - rate field codes 1..10 samples/s, resets 001
// - offset compensation bit, resets to one
// - measure offset first, subtract from reading
// - averaging field n gives 2^n conversions averaged
// - averaging field resets to 101, 32 conversions
// - single-shot trigger starts one averaged ambient measurement
package eac_pkg;
    localparam logic [7:0] EAC_EMIT_OFFSET = 8'h83;
    localparam logic [7:0] EAC_AMB_OFFSET = 8'h84;
    localparam int EAC_TRIM_LSB = 6;
    localparam int EAC_CODE_MSB = 5;
    localparam logic [5:0] EAC_CODE_RST = 6'h02;
    localparam logic [5:0] EAC_CODE_MAX = 6'h14;
    localparam logic [7:0] EAC_STEP_MA = 8'h0a;
    localparam int EAC_CONT_BIT = 7;
    localparam int EAC_RATE_LSB = 4;
    localparam int EAC_OFFS_BIT = 3;
    localparam int EAC_AVG_MSB = 2;
    localparam logic [7:0] EAC_AMB_RST = 8'h1d;
    localparam logic [7:0] EAC_RDATA_RST = 8'h00;
    typedef enum logic [3:0] {
        EAC_S_IDLE = 4'b0001,
        EAC_S_DARK = 4'b0010,
        EAC_S_CONV = 4'b0100,
        EAC_S_DONE = 4'b1000
    } eac_state_t;
endpackage

// [hw/eac_ambient_seq.sv]
`timescale 1ns/1ps
`default_nettype none
module eac_ambient_seq (
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_start,
    input wire logic [2:0] i_avg_log2,
    input wire logic i_offset_en,
    input wire logic i_conv_done,
    input wire logic [15:0] i_conv_data,
    output logic o_conv_req,
    output logic o_conv_dark,
    output logic o_busy,
    output logic o_done,
    output logic [15:0] o_result
);
    eac_pkg::eac_state_t state_q;
    logic [2:0] n_q;
    logic offs_q;
    logic [7:0] cnt_q;
    logic [22:0] sum_q;
    logic [15:0] dark_q;
    logic [15:0] avg;
    logic [7:0] target;

    assign target = 8'h01 << n_q;
    assign avg = 16'(sum_q >> n_q);

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            state_q <= eac_pkg::EAC_S_IDLE;
            n_q <= 3'h0;
            offs_q <= 1'b0;
            cnt_q <= 8'h00;
            sum_q <= 23'h000000;
            dark_q <= 16'h0000;
        end else begin
            unique case (state_q)
                eac_pkg::EAC_S_IDLE: begin
                    // settings frozen per run, late writes cannot tear a run
                    if (i_start) begin
                        n_q <= i_avg_log2;
                        offs_q <= i_offset_en;
                        cnt_q <= 8'h00;
                        sum_q <= 23'h000000;
                        dark_q <= 16'h0000;
                        state_q <= i_offset_en ? eac_pkg::EAC_S_DARK : eac_pkg::EAC_S_CONV;
                    end
                end
                eac_pkg::EAC_S_DARK: begin
                    if (i_conv_done) begin
                        dark_q <= i_conv_data;
                        state_q <= eac_pkg::EAC_S_CONV;
                    end
                end
                eac_pkg::EAC_S_CONV: begin
                    if (i_conv_done) begin
                        sum_q <= sum_q + {7'h00, i_conv_data};
                        cnt_q <= cnt_q + 8'h01;
                        if (cnt_q + 8'h01 == target) begin
                            state_q <= eac_pkg::EAC_S_DONE;
                        end
                    end
                end
                eac_pkg::EAC_S_DONE: begin
                    state_q <= eac_pkg::EAC_S_IDLE;
                end
                default: begin
                    state_q <= eac_pkg::EAC_S_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            o_result <= 16'h0000;
            o_done <= 1'b0;
        end else begin
            o_done <= state_q == eac_pkg::EAC_S_DONE;
            if (state_q == eac_pkg::EAC_S_DONE) begin
                // floor at zero so a dark reading above light cannot wrap
                if (offs_q && dark_q >= avg) begin
                    o_result <= 16'h0000;
                end else if (offs_q) begin
                    o_result <= avg - dark_q;
                end else begin
                    o_result <= avg;
                end
            end
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            o_conv_req <= 1'b0;
            o_conv_dark <= 1'b0;
            o_busy <= 1'b0;
        end else begin
            o_busy <= (state_q != eac_pkg::EAC_S_IDLE) || i_start;
            if (state_q == eac_pkg::EAC_S_IDLE) begin
                o_conv_req <= i_start;
                o_conv_dark <= i_start && i_offset_en;
            end else if (state_q == eac_pkg::EAC_S_DARK) begin
                o_conv_req <= 1'b1;
                o_conv_dark <= !i_conv_done;
            end else if (state_q == eac_pkg::EAC_S_CONV) begin
                o_conv_req <= !(i_conv_done && (cnt_q + 8'h01 == target));
                o_conv_dark <= 1'b0;
            end else begin
                o_conv_req <= 1'b0;
                o_conv_dark <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// [hw/eac_regs.sv]
`timescale 1ns/1ps
`default_nettype none
module eac_regs (
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic [7:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    output logic [7:0] o_reg_rdata,
    input wire logic [1:0] i_trim_program_revision,
    input wire logic i_selftimed_en,
    input wire logic i_ambient_single_shot_trigger,
    output logic o_single_shot_clear,
    output logic [7:0] o_emitter_drive_ma,
    output logic [5:0] o_emitter_drive_code,
    output logic o_cont_conv_en,
    output logic [2:0] o_ambient_rate_code,
    output logic o_conv_req,
    output logic o_conv_dark,
    input wire logic i_conv_done,
    input wire logic [15:0] i_conv_data,
    output logic o_ambient_busy,
    output logic o_ambient_valid,
    output logic [15:0] o_ambient_result
);
    logic [5:0] code_q;
    logic [7:0] amb_q;
    logic [1:0] trim_meta_q;
    logic [1:0] trim_q;
    logic st_q;
    logic trig_q;
    logic start;
    logic done;
    logic [5:0] clamped;

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            trim_meta_q <= 2'h0;
            trim_q <= 2'h0;
        end else begin
            trim_meta_q <= i_trim_program_revision;
            trim_q <= trim_meta_q;
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            code_q <= eac_pkg::EAC_CODE_RST;
            amb_q <= eac_pkg::EAC_AMB_RST;
        end else if (i_reg_wr) begin
            if (i_reg_addr == eac_pkg::EAC_EMIT_OFFSET) begin
                code_q <= i_reg_wdata[eac_pkg::EAC_CODE_MSB:0];
            end
            if (i_reg_addr == eac_pkg::EAC_AMB_OFFSET) begin
                amb_q <= i_reg_wdata;
            end
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            o_reg_rdata <= eac_pkg::EAC_RDATA_RST;
        end else if (i_reg_rd) begin
            if (i_reg_addr == eac_pkg::EAC_EMIT_OFFSET) begin
                o_reg_rdata <= {trim_q, code_q};
            end else if (i_reg_addr == eac_pkg::EAC_AMB_OFFSET) begin
                o_reg_rdata <= amb_q;
            end else begin
                o_reg_rdata <= 8'h00;
            end
        end
    end

    assign clamped = (code_q > eac_pkg::EAC_CODE_MAX) ? eac_pkg::EAC_CODE_MAX : code_q;

    // drive tracks the register only outside a self-timed run
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            o_emitter_drive_code <= eac_pkg::EAC_CODE_RST;
            o_emitter_drive_ma <= 8'(eac_pkg::EAC_CODE_RST * eac_pkg::EAC_STEP_MA);
            st_q <= 1'b0;
        end else begin
            st_q <= i_selftimed_en;
            if (!(i_selftimed_en && st_q)) begin
                o_emitter_drive_code <= clamped;
                o_emitter_drive_ma <= 8'({2'h0, clamped} * eac_pkg::EAC_STEP_MA);
            end
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            o_cont_conv_en <= eac_pkg::EAC_AMB_RST[eac_pkg::EAC_CONT_BIT];
            o_ambient_rate_code <= eac_pkg::EAC_AMB_RST[eac_pkg::EAC_RATE_LSB +: 3];
        end else begin
            o_cont_conv_en <= amb_q[eac_pkg::EAC_CONT_BIT];
            o_ambient_rate_code <= amb_q[eac_pkg::EAC_RATE_LSB +: 3];
        end
    end

    // on-demand runs are blocked while self-timed mode owns the sensor
    assign start = !i_selftimed_en && !o_ambient_busy && i_ambient_single_shot_trigger
                   && (!trig_q || amb_q[eac_pkg::EAC_CONT_BIT]);

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            trig_q <= 1'b0;
            o_single_shot_clear <= 1'b0;
            o_ambient_valid <= 1'b0;
        end else begin
            trig_q <= i_ambient_single_shot_trigger;
            o_single_shot_clear <= done && !amb_q[eac_pkg::EAC_CONT_BIT];
            o_ambient_valid <= done;
        end
    end

    eac_ambient_seq u_seq (
        .i_core_clk(i_core_clk),
        .i_rst(i_rst),
        .i_start(start),
        .i_avg_log2(amb_q[eac_pkg::EAC_AVG_MSB:0]),
        .i_offset_en(amb_q[eac_pkg::EAC_OFFS_BIT]),
        .i_conv_done(i_conv_done),
        .i_conv_data(i_conv_data),
        .o_conv_req(o_conv_req),
        .o_conv_dark(o_conv_dark),
        .o_busy(o_ambient_busy),
        .o_done(done),
        .o_result(o_ambient_result)
    );
endmodule
`default_nettype wire

// [hw/eac_pad_unused.sv]
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// [test/eac_fe_model.sv]
`timescale 1ns/1ps
`default_nettype none
module eac_fe_model (
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_conv_req,
    input wire logic i_conv_dark,
    input wire logic [15:0] i_dv,
    input wire logic [15:0] i_lv,
    output logic o_conv_done,
    output logic [15:0] o_conv_data
);
    logic [1:0] cnt_q;
    logic alt_q;
    logic take;
    assign take = i_conv_req && cnt_q == 2'h2;
    // dark sample first, then lit samples
    // lit samples alternate lv and lv+2, so a wrong count shows in the average
    // data scrambled outside the done pulse, so a late read is caught
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            cnt_q <= 2'h0;
            alt_q <= 1'h0;
            o_conv_done <= 1'h0;
            o_conv_data <= 16'h0000;
        end else begin
            cnt_q <= (i_conv_req && cnt_q != 2'h2) ? cnt_q + 2'h1 : 2'h0;
            alt_q <= i_conv_req && (alt_q ^ (take && !i_conv_dark));
            o_conv_done <= take;
            if (take) begin
                o_conv_data <= i_conv_dark ? i_dv : i_lv + {14'h0000, alt_q, 1'h0};
            end else begin
                o_conv_data <= ~o_conv_data;
            end
        end
    end
endmodule
`default_nettype wire

// [test/eac_regs_chk.sv]
`timescale 1ns/1ps
`default_nettype none
module eac_regs_chk (
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic [7:0] i_reg_addr,
    input wire logic i_reg_rd,
    input wire logic [7:0] o_reg_rdata,
    input wire logic i_selftimed_en,
    input wire logic i_ambient_single_shot_trigger,
    input wire logic o_single_shot_clear,
    input wire logic [7:0] o_emitter_drive_ma,
    input wire logic [5:0] o_emitter_drive_code,
    input wire logic o_cont_conv_en,
    input wire logic o_conv_req,
    input wire logic o_ambient_busy,
    input wire logic o_ambient_valid,
    input wire logic [15:0] o_ambient_result
);
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (i_rst);
    a_drive_scale: assert property (o_emitter_drive_ma == {2'h0, o_emitter_drive_code} * 8'h0a)
        else $error("drive not ten times code");
    a_code_clamp: assert property (o_emitter_drive_code <= 6'h14)
        else $error("code above clamp");
    a_drive_frozen: assert property (i_selftimed_en [*3] |=> $stable(o_emitter_drive_code))
        else $error("drive moved in self-timed run");
    a_rdata_holds: assert property (!i_reg_rd |=> $stable(o_reg_rdata))
        else $error("read data moved without read");
    a_unmapped_zero: assert property (i_reg_rd && i_reg_addr != 8'h83 && i_reg_addr != 8'h84
        |=> o_reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_trigger_starts: assert property ($rose(i_ambient_single_shot_trigger)
        && !i_selftimed_en && !o_ambient_busy |=> o_conv_req && o_ambient_busy)
        else $error("trigger did not start run");
    a_valid_pulse: assert property (o_ambient_valid |=> !o_ambient_valid)
        else $error("valid longer than one cycle");
    a_result_valid: assert property ($changed(o_ambient_result)
        |=> o_ambient_valid && (o_single_shot_clear == !o_cont_conv_en))
        else $error("result change without valid");
endmodule
bind eac_regs eac_regs_chk u_chk (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_reg_addr(i_reg_addr),
    .i_reg_rd(i_reg_rd),
    .o_reg_rdata(o_reg_rdata),
    .i_selftimed_en(i_selftimed_en),
    .i_ambient_single_shot_trigger(i_ambient_single_shot_trigger),
    .o_single_shot_clear(o_single_shot_clear),
    .o_emitter_drive_ma(o_emitter_drive_ma),
    .o_emitter_drive_code(o_emitter_drive_code),
    .o_cont_conv_en(o_cont_conv_en),
    .o_conv_req(o_conv_req),
    .o_ambient_busy(o_ambient_busy),
    .o_ambient_valid(o_ambient_valid),
    .o_ambient_result(o_ambient_result)
);
`default_nettype wire

// [test/tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk = 1'h0, rst = 1'h1, wr = 1'h0, rd = 1'h0, st = 1'h0, trg = 1'h0;
    logic [1:0] trim = 2'h2;
    logic [7:0] addr = 8'h00, wd = 8'h00;
    logic [15:0] dv = 16'h0000, lv = 16'h0000;
    logic done, req, dark, busy, vld, clr, cont;
    logic [7:0] rdata, ma;
    logic [5:0] code;
    logic [2:0] rate;
    logic [15:0] cdata, res;
    logic [5:0] cs [5] = '{6'h00, 6'h07, 6'h14, 6'h15, 6'h3f};
    int fails = 0, compares = 0;
    eac_regs DUT (.i_core_clk(clk), .i_rst(rst), .i_reg_addr(addr), .i_reg_wdata(wd), .i_reg_wr(wr),
        .i_reg_rd(rd), .o_reg_rdata(rdata), .i_trim_program_revision(trim), .i_selftimed_en(st),
        .i_ambient_single_shot_trigger(trg), .o_single_shot_clear(clr), .o_emitter_drive_ma(ma),
        .o_emitter_drive_code(code), .o_cont_conv_en(cont), .o_ambient_rate_code(rate), .o_conv_req(req),
        .o_conv_dark(dark), .i_conv_done(done), .i_conv_data(cdata), .o_ambient_busy(busy),
        .o_ambient_valid(vld), .o_ambient_result(res));
    eac_fe_model FE (.i_core_clk(clk), .i_rst(rst), .i_conv_req(req), .i_conv_dark(dark), .i_dv(dv),
        .i_lv(lv), .o_conv_done(done), .o_conv_data(cdata));
    initial begin
        forever #20 clk = ~clk;
    end
    task automatic chk(string n, logic [15:0] s, logic [15:0] e);
        compares++;
        if (s !== e) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic tick(int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wreg(logic [7:0] a, logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wd <= d;
        wr <= 1'h1;
        @(posedge clk);
        wr <= 1'h0;
    endtask
    task automatic rreg(logic [7:0] a, logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'h1;
        @(posedge clk);
        rd <= 1'h0;
        #1 chk("rdata", {8'h00, rdata}, {8'h00, e});
    endtask
    task automatic t_regs();
        rreg(8'h84, 8'h1d);
        rreg(8'h83, 8'h82);
        chk("ma", {8'h00, ma}, 16'h0014);
        for (int i = 0; i < 5; i++) begin
            wreg(8'h83, {2'h1, cs[i]});
            tick(2);
            chk("ma", {8'h00, ma}, cs[i] > 6'h14 ? 16'h00c8 : {10'h000, cs[i]} * 16'h000a);
            rreg(8'h83, {2'h2, cs[i]});
        end
        // config written only while idle
        for (int r = 0; r < 8; r++) begin
            wreg(8'h84, {1'h1, 3'(r), 4'h5});
            tick(2);
            chk("rate", {13'h0000, rate}, 16'(r));
            chk("cont", {15'h0000, cont}, 16'h0001);
        end
        wreg(8'h85, 8'hff);
        rreg(8'h85, 8'h00);
        rreg(8'h84, 8'hf5);
        // pin passes two flops before it reads back
        @(posedge clk);
        trim <= 2'h1;
        tick(2);
        rreg(8'h83, 8'h7f);
    endtask
    task automatic t_freeze();
        wreg(8'h83, 8'h05);
        @(posedge clk);
        st <= 1'h1;
        tick(3);
        wreg(8'h83, 8'h09);
        tick(3);
        chk("ma", {8'h00, ma}, 16'h0032);
        @(posedge clk);
        trg <= 1'h1;
        tick(10);
        chk("req", {15'h0000, req}, 16'h0000);
        @(posedge clk);
        st <= 1'h0;
        trg <= 1'h0;
        tick(3);
        chk("ma", {8'h00, ma}, 16'h005a);
    endtask
    task automatic meas(logic [7:0] cfg, logic [15:0] d, logic [15:0] l, logic [15:0] e);
        int n = 0;
        // single-shot only, continuous bit kept low
        wreg(8'h84, cfg);
        @(posedge clk);
        dv <= d;
        lv <= l;
        trg <= 1'h1;
        tick(1);
        while (vld !== 1'h1 && n < 1000) begin
            tick(1);
            n++;
        end
        chk("clear", {15'h0000, clr}, 16'h0001);
        chk("result", res, e);
        @(posedge clk);
        trg <= 1'h0;
    endtask
    task automatic t_cont();
        int runs = 0;
        // continuous mode paired with single-shot only
        wreg(8'h84, 8'h80);
        @(posedge clk);
        lv <= 16'h0033;
        trg <= 1'h1;
        repeat (40) begin
            tick(1);
            if (vld === 1'h1) begin
                runs++;
                chk("clear", {15'h0000, clr}, 16'h0000);
                chk("result", res, 16'h0033);
            end
        end
        chk("runs", {15'h0000, runs > 3}, 16'h0001);
        // reset lands in the middle of a run
        @(posedge clk);
        rst <= 1'h1;
        repeat (5) @(posedge clk);
        rst <= 1'h0;
        trg <= 1'h0;
        rreg(8'h84, 8'h1d);
        rreg(8'h83, 8'h42);
        chk("busy", {15'h0000, busy}, 16'h0000);
        chk("ma", {8'h00, ma}, 16'h0014);
    endtask
    task automatic tally_and_finish();
        if (fails == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'h0;
        t_regs();
        t_freeze();
        t_cont();
        meas(8'h09, 16'h0010, 16'h0050, 16'h0041);
        meas(8'h08, 16'h0060, 16'h0050, 16'h0000);
        meas(8'h07, 16'h0010, 16'h1234, 16'h1235);
        meas(8'h1d, 16'h0005, 16'h0105, 16'h0101);
        tally_and_finish();
    end
    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
